// file: uart_status_pkg.sv
// Shared constants for the UART line and modem status block.
// Assumes a 32-bit APB bus with one register per aligned word.
package uart_status_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IDX_RECEIVE_BUFFER   = 6'h00;
  localparam logic [5:0] IDX_MODEM_CONTROL    = 6'h04;
  localparam logic [5:0] IDX_RECEIVE_LINE     = 6'h05;
  localparam logic [5:0] IDX_MODEM_LINE       = 6'h06;
  localparam logic [5:0] IDX_RX_CONTROL       = 6'h08;
  localparam logic [5:0] IDX_IRQ_STATUS       = 6'h09;
  localparam logic [5:0] IDX_IRQ_MASK         = 6'h0A;

  // Line status field positions.
  localparam int LINE_READY_BIT   = 0;
  localparam int LINE_OVERRUN_BIT = 1;
  localparam int LINE_PARITY_BIT  = 2;

  // Modem control field positions.
  localparam int CTRL_DTR_BIT      = 0;
  localparam int CTRL_RTS_BIT      = 1;
  localparam int CTRL_USER_ONE_BIT = 2;
  localparam int CTRL_USER_TWO_BIT = 3;
  localparam int CTRL_LOOP_BIT     = 4;

  // Receive control field positions.
  localparam int CTL_FIFO_EN_BIT = 0;
  localparam int CTL_FLUSH_BIT   = 1;

  // Interrupt status and mask field positions.
  localparam int IRQ_READY_BIT   = 0;
  localparam int IRQ_OVERRUN_BIT = 1;
  localparam int IRQ_PARITY_BIT  = 2;
  localparam int IRQ_MODEM_BIT   = 3;

  // Reset values.
  localparam logic [7:0] MODEM_CTL_RESET = 8'h00;
  localparam logic [7:0] CTL_RESET       = 8'h00;
  localparam logic [3:0] IRQ_MASK_RESET  = 4'h0;

  // Receive FIFO depth.
  localparam int RX_FIFO_DEPTH = 16;

endpackage

// file: uart_rx_fifo.sv
// Receive FIFO holding each character together with its parity flag.
// Assumes the caller never pushes when full nor pops when empty.
`timescale 1ns/1ps
module uart_rx_fifo
  #(parameter int WIDTH = 9,
    parameter int DEPTH = 16)
  (
  input  wire logic             i_clk,   // System clock.
  input  wire logic             i_srst,  // Synchronous reset.
  input  wire logic             i_flush, // Empties the FIFO.
  input  wire logic             i_push,  // Write one entry.
  input  wire logic [WIDTH-1:0] i_data,  // Entry to write.
  input  wire logic             i_pop,   // Drop the head entry.
  output logic      [WIDTH-1:0] o_head,  // Head entry.
  output logic                  o_empty, // No entry held.
  output logic                  o_full   // All entries held.
  );

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;

  always_ff @(posedge i_clk)
  begin
    if (i_push)
    begin
      mem[wr_ptr] <= i_data;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst || i_flush)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (i_push)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (i_pop)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(i_push) - (AW+1)'(i_pop);
    end
  end

  assign o_head  = mem[rd_ptr];
  assign o_empty = (count == '0);
  assign o_full  = (count == (AW+1)'(DEPTH));

endmodule // uart_rx_fifo

// file: uart_line_modem_status.sv
// Receive line status, modem status and interrupt logic of a UART channel.
// Assumes a receiver on the same clock delivering assembled characters and
// modem lines arriving asynchronously from a peripheral.
//
// Functional notes
// [RQ1] A new valid character in the buffer clears the parity error flag.
// [RQ2] FIFO mode: parity error travels with its character, shown at head.
// [RQ3] Buffer mode: unread character is overwritten and overrun bit 1 set.
// [RQ4] FIFO mode: overrun only when FIFO full and another character done.
// [RQ5] FIFO overrun discards the shift register character, never pushed.
// [RQ6] Overrun is shown at once, not when reaching the FIFO head.
// [RQ7] Overrun set at stop bit time, cleared by reading line status.
// [RQ8] Data ready bit 0 set once a character is in buffer or FIFO.
// [RQ9] Data ready clears only when every pending character was read; a flush or FIFO enable change also clears it.
// [RQ10] Four change bits set on input change, cleared by reading offset 6.
// [RQ11] Bit 7 is inverted carrier detect, or user output two in loopback.
// [RQ12] Bit 6 is inverted ring indicator, or user output one in loopback.
// [RQ13] Bit 5 is inverted data set ready, or DTR in loopback.
// [RQ14] Bit 4 is inverted clear to send, or RTS in loopback.
// [RQ15] Bit 3 set on any carrier detect change since last read.
// [RQ16] Bit 2 set only when ring input went from 0 to 1.
// [RQ17] Modem interrupt raised whenever any of bits 0 to 3 becomes set.
// [RQ18] Modem inputs are synchronised before edge detection.
`timescale 1ns/1ps
module uart_line_modem_status
  import uart_status_pkg::*;
  #(parameter int FIFO_DEPTH = RX_FIFO_DEPTH)
  (
  input  wire logic        i_clk,        // System clock, 125 MHz.
  input  wire logic        i_srst,       // Synchronous reset, active high.
  input  wire logic [7:0]  i_paddr,      // APB byte address.
  input  wire logic        i_psel,       // APB select.
  input  wire logic        i_penable,    // APB enable.
  input  wire logic        i_pwrite,     // APB write.
  input  wire logic [31:0] i_pwdata,     // APB write data.
  input  wire logic [3:0]  i_pstrb,      // APB byte strobes.
  output logic      [31:0] o_prdata,     // APB read data.
  output logic             o_pready,     // APB ready.
  output logic             o_pslverr,    // APB error.
  input  wire logic        i_rx_valid,   // Character assembled, stop bit.
  input  wire logic [7:0]  i_rx_char,    // Assembled character.
  input  wire logic        i_rx_perr,    // Parity error of that character.
  input  wire logic        i_cts_n,      // Clear to send, active low.
  input  wire logic        i_dsr_n,      // Data set ready, active low.
  input  wire logic        i_ri_n,       // Ring indicator, active low.
  input  wire logic        i_dcd_n,      // Carrier detect, active low.
  output logic             o_irq         // Interrupt, active high level.
  );

  // Modem line order: 0 clear to send, 1 data set ready, 2 ring, 3 carrier.
  logic [3:0] modem_n_pin;
  logic [3:0] modem_n_meta;
  logic [3:0] modem_n_sync;
  logic [3:0] modem_now;
  logic [3:0] modem_prev;
  logic       modem_primed;
  logic [3:0] modem_delta;
  logic [3:0] delta_set;

  logic [7:0] modem_control_reg;
  logic [7:0] rx_control;
  logic       fifo_mode;
  logic       loopback;

  logic       rb_valid;
  logic [7:0] rb_data;
  logic       rb_perr;
  logic       overrun_flag;
  logic       rx_ready_flag;
  logic       parity_err_flag;
  logic       parity_prev;

  logic       fifo_flush;
  logic       fifo_push;
  logic       fifo_pop;
  logic [8:0] fifo_head;
  logic       fifo_empty;
  logic       fifo_full;

  logic [3:0] irq_status;
  logic [3:0] irq_mask;
  logic [3:0] irq_event;

  logic       access;
  logic       wr_en;
  logic       rd_en;
  logic [5:0] index;
  logic       mapped;
  logic [7:0] receive_line_state;
  logic [7:0] modem_line_state;
  logic [7:0] next_rdata;
  logic       rxbuf_rd;
  logic       line_rd;
  logic       modem_rd;
  logic       overrun_evt;
  logic       char_loaded;

  assign modem_n_pin = {i_dcd_n, i_ri_n, i_dsr_n, i_cts_n};

  // Two flops per line; only the second stage feeds the edge logic.
  for (genvar g = 0; g < 4; g++)
  begin : g_modem_sync
    always_ff @(posedge i_clk)
    begin
      if (i_srst)
      begin
        modem_n_meta[g] <= 1'b1;
        modem_n_sync[g] <= 1'b1;
      end
      else
      begin
        modem_n_meta[g] <= modem_n_pin[g]; // RQ18
        modem_n_sync[g] <= modem_n_meta[g]; // RQ18
      end
    end
  end

  // APB access phase; the answer comes one cycle after the first access edge.
  assign access = i_psel && i_penable && !o_pready;
  assign index  = i_paddr[7:2];
  assign mapped = (i_paddr[1:0] == 2'b00) &&
                  (index == IDX_RECEIVE_BUFFER || index == IDX_MODEM_CONTROL ||
                   index == IDX_RECEIVE_LINE || index == IDX_MODEM_LINE ||
                   index == IDX_RX_CONTROL || index == IDX_IRQ_STATUS ||
                   index == IDX_IRQ_MASK);
  assign wr_en  = access && i_pwrite && mapped && i_pstrb[0];
  assign rd_en  = access && !i_pwrite && mapped;
  assign rxbuf_rd = rd_en && (index == IDX_RECEIVE_BUFFER);
  assign line_rd  = rd_en && (index == IDX_RECEIVE_LINE);
  assign modem_rd = rd_en && (index == IDX_MODEM_LINE);

  assign fifo_mode = rx_control[CTL_FIFO_EN_BIT];
  assign loopback  = modem_control_reg[CTRL_LOOP_BIT];

  // Loopback routes the control outputs back in place of the pins.
  assign modem_now = loopback ?
    {modem_control_reg[CTRL_USER_TWO_BIT],
     modem_control_reg[CTRL_USER_ONE_BIT],
     modem_control_reg[CTRL_DTR_BIT], modem_control_reg[CTRL_RTS_BIT]} :
    ~modem_n_sync; // RQ11 RQ12 RQ13 RQ14

  // Ring input rising means the active-high view falls.
  assign delta_set = modem_primed ?
    {modem_now[3] ^ modem_prev[3], // RQ15
     modem_prev[2] & ~modem_now[2], // RQ16
     modem_now[1:0] ^ modem_prev[1:0]} : 4'h0; // RQ10

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      modem_prev   <= 4'h0;
      modem_primed <= 1'b0;
      modem_delta  <= 4'h0;
    end
    else
    begin
      modem_prev   <= modem_now;
      modem_primed <= 1'b1;
      // A change in the cycle of the read survives the clear.
      modem_delta  <= (modem_rd ? 4'h0 : modem_delta) | delta_set; // RQ10
    end
  end

  assign modem_line_state = {modem_now, modem_delta};

  // Control registers.
  assign fifo_flush = wr_en && (index == IDX_RX_CONTROL) &&
                      (i_pwdata[CTL_FLUSH_BIT] ||
                       i_pwdata[CTL_FIFO_EN_BIT] != fifo_mode);

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      modem_control_reg <= MODEM_CTL_RESET;
      rx_control        <= CTL_RESET;
      irq_mask          <= IRQ_MASK_RESET;
    end
    else if (wr_en)
    begin
      unique case (index)
        IDX_MODEM_CONTROL: modem_control_reg <= {3'b000, i_pwdata[4:0]};
        IDX_RX_CONTROL:    rx_control <= {7'b0000_000, i_pwdata[0]};
        IDX_IRQ_MASK:      irq_mask <= i_pwdata[3:0];
        default:           ;
      endcase
    end
  end

  // FIFO mode: a full FIFO drops the new character instead of storing it.
  assign fifo_push   = i_rx_valid && fifo_mode && !fifo_full; // RQ5
  assign fifo_pop    = rxbuf_rd && fifo_mode && !fifo_empty;
  assign overrun_evt = i_rx_valid &&
                       (fifo_mode ? fifo_full // RQ4
                                  : (rb_valid && !rxbuf_rd)); // RQ3
  assign char_loaded = fifo_push || (i_rx_valid && !fifo_mode);

  uart_rx_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_rx_fifo
  (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_flush (fifo_flush),
    .i_push  (fifo_push),
    .i_data  ({i_rx_perr, i_rx_char}), // RQ2
    .i_pop   (fifo_pop),
    .o_head  (fifo_head),
    .o_empty (fifo_empty),
    .o_full  (fifo_full)
  );

  // Single holding buffer used outside FIFO mode.
  always_ff @(posedge i_clk)
  begin
    if (i_srst || fifo_flush)
    begin
      rb_valid <= 1'b0;
      rb_data  <= 8'h00;
      rb_perr  <= 1'b0;
    end
    else if (i_rx_valid && !fifo_mode)
    begin
      rb_valid <= 1'b1;
      rb_data  <= i_rx_char; // RQ3
      rb_perr  <= i_rx_perr; // RQ1
    end
    else
    begin
      if (rxbuf_rd && !fifo_mode)
      begin
        rb_valid <= 1'b0; // RQ9
      end
      if (line_rd)
      begin
        rb_perr <= 1'b0;
      end
    end
  end

  // Overrun shows at once, set at stop bit time; set wins over the clear.
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      overrun_flag <= 1'b0;
    end
    else if (overrun_evt)
    begin
      overrun_flag <= 1'b1; // RQ6 RQ7
    end
    else if (line_rd)
    begin
      overrun_flag <= 1'b0; // RQ7
    end
  end

  assign rx_ready_flag   = fifo_mode ? !fifo_empty : rb_valid; // RQ8 RQ9
  assign parity_err_flag = fifo_mode ? (!fifo_empty && fifo_head[8]) // RQ2
                                     : rb_perr;

  assign receive_line_state = {5'b0_0000, parity_err_flag, overrun_flag,
                               rx_ready_flag};

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      parity_prev <= 1'b0;
    end
    else
    begin
      parity_prev <= parity_err_flag;
    end
  end

  assign irq_event[IRQ_READY_BIT]   = char_loaded;
  assign irq_event[IRQ_OVERRUN_BIT] = overrun_evt;
  assign irq_event[IRQ_PARITY_BIT]  = parity_err_flag && !parity_prev;
  assign irq_event[IRQ_MODEM_BIT]   = |delta_set; // RQ17

  // Sticky status, cleared by writing one; a new event wins over the clear.
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      irq_status <= 4'h0;
    end
    else if (wr_en && index == IDX_IRQ_STATUS)
    begin
      irq_status <= (irq_status & ~i_pwdata[3:0]) | irq_event;
    end
    else
    begin
      irq_status <= irq_status | irq_event;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_irq <= 1'b0;
    end
    else
    begin
      o_irq <= |((irq_status | irq_event) & irq_mask); // RQ17
    end
  end

  always_comb
  begin
    next_rdata = 8'h00;
    unique case (index)
      // An empty FIFO reads as zero rather than a stale or unset entry.
      IDX_RECEIVE_BUFFER: next_rdata = !fifo_mode ? rb_data :
                                       fifo_empty ? 8'h00 : fifo_head[7:0];
      IDX_MODEM_CONTROL:  next_rdata = modem_control_reg;
      IDX_RECEIVE_LINE:   next_rdata = receive_line_state;
      IDX_MODEM_LINE:     next_rdata = modem_line_state;
      IDX_RX_CONTROL:     next_rdata = rx_control;
      IDX_IRQ_STATUS:     next_rdata = {4'h0, irq_status};
      IDX_IRQ_MASK:       next_rdata = {4'h0, irq_mask};
      default:            next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end
    else if (access)
    begin
      o_pready  <= 1'b1;
      o_prdata  <= (i_pwrite || !mapped) ? 32'h0000_0000
                                         : {24'h00_0000, next_rdata};
      o_pslverr <= !mapped;
    end
    else
    begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end
  end

endmodule // uart_line_modem_status

// file: uart_status_properties.sv
// Port-level checks for the line and modem status block.
// Assumes one clock domain and an APB master as the only host.
`timescale 1ns/1ps
module uart_status_checker
  (
  input wire logic        i_clk,     // Clock.
  input wire logic        i_srst,    // Reset.
  input wire logic [7:0]  i_paddr,   // Address.
  input wire logic        i_psel,    // Select.
  input wire logic        i_penable, // Enable.
  input wire logic        i_pwrite,  // Write.
  input wire logic [31:0] o_prdata,  // Read data.
  input wire logic        o_pready,  // Ready.
  input wire logic        o_pslverr, // Error.
  input wire logic        i_rx_valid,// Character strobe.
  input wire logic        o_irq      // Interrupt.
  );
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  logic take;
  assign take = i_psel & i_penable & ~o_pready;
  property p_ready_pulse;
    take |=> o_pready ##1 !o_pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("bad pready");
  property p_ready_held;
    o_pready |-> i_psel && i_penable;
  endproperty
  a_ready_held: assert property (p_ready_held) else $error("stray pready");
  property p_rdata_idle;
    !o_pready |-> o_prdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("rdata idle");
  property p_err_align;
    take && i_paddr[1:0] != 2'b00 |=> o_pslverr;
  endproperty
  a_err_align: assert property (p_err_align) else $error("no slverr");
  property p_err_mapped;
    take && i_paddr == 8'h14 |=> !o_pslverr;
  endproperty
  a_err_mapped: assert property (p_err_mapped) else $error("bad slverr");
  property p_err_ready;
    o_pslverr |-> o_pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("slverr alone");
  property p_line_top;
    o_pready && !i_pwrite && i_paddr == 8'h14 |-> o_prdata[31:3] == '0;
  endproperty
  a_line_top: assert property (p_line_top) else $error("line upper bits");
  property p_modem_top;
    o_pready && !i_pwrite && i_paddr == 8'h18 |-> o_prdata[31:8] == '0;
  endproperty
  a_modem_top: assert property (p_modem_top) else $error("modem upper bits");
  c_rx: cover property (i_rx_valid);
  c_err: cover property (o_pslverr);
  c_irq: cover property ($rose(o_irq));
endmodule // uart_status_checker

bind uart_line_modem_status uart_status_checker u_chk
  (.i_clk(i_clk), .i_srst(i_srst), .i_paddr(i_paddr), .i_psel(i_psel),
   .i_penable(i_penable), .i_pwrite(i_pwrite), .o_prdata(o_prdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .i_rx_valid(i_rx_valid),
   .o_irq(o_irq));

// file: modem_peer.sv
// Behavioural modem driving the four active-low handshake lines.
// Lines move 3 ns after a level request, unrelated to the clock.
`timescale 1ns/1ps
module modem_peer
  (
  input  wire logic [3:0] i_level, // Levels {dcd, ri, dsr, cts}.
  output logic            o_cts_n, // Clear to send.
  output logic            o_dsr_n, // Data set ready.
  output logic            o_ri_n,  // Ring indicator.
  output logic            o_dcd_n  // Carrier detect.
  );
  initial
  begin
    {o_dcd_n, o_ri_n, o_dsr_n, o_cts_n} = 4'hF;
  end
  always @(i_level)
    {o_dcd_n, o_ri_n, o_dsr_n, o_cts_n} <= #3 i_level;
endmodule // modem_peer

// file: tb.sv
// Self-checking bench for the line and modem status block.
// Drives APB, the receiver strobe and a modem peer on one clock.
`timescale 1ns/1ps
module tb;
  import uart_status_pkg::*;
  localparam logic [7:0] adr_buf = {IDX_RECEIVE_BUFFER, 2'b00};
  localparam logic [7:0] adr_mct = {IDX_MODEM_CONTROL, 2'b00};
  localparam logic [7:0] adr_lin = {IDX_RECEIVE_LINE, 2'b00};
  localparam logic [7:0] adr_mdm = {IDX_MODEM_LINE, 2'b00};
  localparam logic [7:0] adr_ctl = {IDX_RX_CONTROL, 2'b00};
  localparam logic [7:0] adr_sts = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [7:0] adr_msk = {IDX_IRQ_MASK, 2'b00};
  logic        clk = 0;
  logic        srst = 1;
  logic [7:0]  paddr = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [31:0] pwdata = 0;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_valid = 0;
  logic [7:0]  rx_char = 0;
  logic        rx_perr = 0;
  logic [3:0]  level = 4'hF;
  logic        cts_n, dsr_n, ri_n, dcd_n, irq;
  int          fails = 0;
  int          samples_checked = 0;
  always #4 clk = ~clk;
  uart_line_modem_status #(.FIFO_DEPTH(4)) dut
    (.i_clk(clk), .i_srst(srst), .i_paddr(paddr), .i_psel(psel),
     .i_penable(penable), .i_pwrite(pwrite), .i_pwdata(pwdata),
     .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
     .o_pslverr(pslverr), .i_rx_valid(rx_valid), .i_rx_char(rx_char),
     .i_rx_perr(rx_perr), .i_cts_n(cts_n), .i_dsr_n(dsr_n),
     .i_ri_n(ri_n), .i_dcd_n(dcd_n), .o_irq(irq));
  modem_peer peer
    (.i_level(level), .o_cts_n(cts_n), .o_dsr_n(dsr_n),
     .o_ri_n(ri_n), .o_dcd_n(dcd_n));
  task print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // The request is held until pready is seen high at a rising edge.
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d,
           output logic [7:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    r = prdata[7:0];
    e = pslverr;
    if (n == 20)
      chk("pready", 1, 0);
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic       e;
    apb(1, a, d, r, e);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] x, input string n);
    logic [7:0] r;
    logic       e;
    apb(0, a, 0, r, e);
    chk(n, x, r);
  endtask
  task rx(input logic [7:0] c, input logic p);
    @(posedge clk);
    rx_valid <= 1;
    rx_char <= c;
    rx_perr <= p;
    @(posedge clk);
    rx_valid <= 0;
  endtask
  task t_reset;
    logic [7:0] r;
    logic       e;
    rd(adr_lin, 8'h00, "line state");
    rd(adr_mdm, 8'h00, "modem state");
    rd(adr_mct, 8'h00, "modem control");
    pstrb <= 4'h0;
    wr(adr_mct, 8'h1F);
    pstrb <= 4'hF;
    rd(adr_mct, 8'h00, "strobe off");
    apb(0, 8'h3C, 0, r, e);
    chk("unmapped", 1, {7'h00, e});
    apb(0, 8'h15, 0, r, e);
    chk("misaligned", 1, {7'h00, e});
    $display("test reset done");
  endtask
  task t_buffer;
    rx(8'h41, 1);
    rx(8'h42, 0);
    rd(adr_lin, 8'h03, "line state");
    rd(adr_lin, 8'h01, "line state");
    rd(adr_buf, 8'h42, "rx buffer");
    rd(adr_lin, 8'h00, "line state");
    rx(8'h43, 1);
    rd(adr_lin, 8'h05, "line state");
    rd(adr_buf, 8'h43, "rx buffer");
    rd(adr_lin, 8'h00, "line state");
    $display("test buffer done");
  endtask
  task t_fifo;
    wr(adr_ctl, 8'h01);
    for (int i = 0; i < 4; i++)
      rx(8'h10 + i[7:0], i == 1);
    rd(adr_lin, 8'h01, "line state");
    rx(8'h99, 0);
    rd(adr_lin, 8'h03, "line state");
    rd(adr_buf, 8'h10, "rx buffer");
    rd(adr_lin, 8'h05, "line state");
    rd(adr_buf, 8'h11, "rx buffer");
    rd(adr_buf, 8'h12, "rx buffer");
    rd(adr_lin, 8'h01, "line state");
    rd(adr_buf, 8'h13, "rx buffer");
    rd(adr_lin, 8'h00, "line state");
    rx(8'h77, 1);
    rd(adr_lin, 8'h05, "line state");
    wr(adr_ctl, 8'h03);
    rd(adr_ctl, 8'h01, "rx control");
    rd(adr_lin, 8'h00, "line state");
    wr(adr_ctl, 8'h00);
    $display("test fifo done");
  endtask
  task t_modem;
    logic [3:0] lv [10] = '{4'hE, 4'hC, 4'h8, 4'hC, 4'h4,
                            4'hC, 4'hF, 4'hF, 4'hF, 4'hF};
    logic [7:0] mc [10] = '{0, 0, 0, 0, 0, 0, 0, 8'h15, 8'h1A, 0};
    logic [7:0] ms [10] = '{8'h11, 8'h32, 8'h70, 8'h34, 8'hB8,
                            8'h38, 8'h03, 8'h62, 8'h9F, 8'h09};
    for (int i = 0; i < 10; i++)
    begin
      level <= lv[i];
      wr(adr_mct, mc[i]);
      repeat (4) @(posedge clk);
      rd(adr_mdm, ms[i], "modem");
    end
    $display("test modem done");
  endtask
  task t_irq;
    wr(adr_sts, 8'h0F);
    wr(adr_msk, 8'h08);
    rd(adr_msk, 8'h08, "irq mask");
    level <= 4'hE;
    repeat (8) @(posedge clk);
    chk("irq", 1, {7'h00, irq});
    rd(adr_sts, 8'h08, "irq status");
    wr(adr_msk, 8'h00);
    repeat (2) @(posedge clk);
    chk("irq", 0, {7'h00, irq});
    wr(adr_msk, 8'h08);
    repeat (2) @(posedge clk);
    chk("irq", 1, {7'h00, irq});
    wr(adr_sts, 8'h08);
    repeat (2) @(posedge clk);
    chk("irq", 0, {7'h00, irq});
    wr(adr_msk, 8'h01);
    rx(8'h5A, 0);
    repeat (2) @(posedge clk);
    chk("irq", 1, {7'h00, irq});
    rd(adr_buf, 8'h5A, "rx buffer");
    wr(adr_sts, 8'h0F);
    repeat (2) @(posedge clk);
    chk("irq", 0, {7'h00, irq});
    level <= 4'hF;
    $display("test irq done");
  endtask
  initial
  begin
    #100us;
    fails++;
    $display("watchdog expired");
    print_verdict;
  end
  initial
  begin
    repeat (3) @(posedge clk);
    srst <= 0;
    t_reset;
    t_buffer;
    t_fifo;
    t_modem;
    t_irq;
    print_verdict;
  end
endmodule // tb
